//--- hw/hbdma_map.svh
// Function
// - Claim an I/O cycle only at switch base plus a register offset.
// - Claimed reads drive the register; claimed writes capture bus data.
// - DMA group: code at 08H, address bytes 09H-0BH, count bytes 0CH-0DH.
// - One byte per bus-master cycle; resumes in place after bus release.
// - Interrupt-code register is write-only and keeps the low three data bits.
// - Codes disable all, enable one flag source, or start a DMA with completion interrupt.
// - Start address is written upper, middle, lower byte; engine starts there.
// - Twelve-bit count, top four bits in low nibble of upper count byte.
// - Count decrements by one for every byte moved to or from memory.
// - Transmit DMA bytes pass through the transmit register into the FIFO.
// - Direct transmit writes reach the FIFO; transmit-empty interrupt when enabled.
// - Receive DMA bytes pass from FIFO through receive register to memory.
// - A host read reloads the receive register from FIFO; receive-full interrupt follows.
// - Command register writes are forwarded to the protocol module.
// - Each executed command leaves a status code in the read-only status register.
// - One packet in a 1.5 Kbyte transmit FIFO, frames in 13.5 Kbyte receive FIFO; transmit buffer index is 10 bits, so bytes past 1024 wrap to the start.
// - Command 29H sends the buffered packet; it stays buffered for retries.
// - Protocol registers at 00H, 01H, 02H, 03H, 05H on a 3-bit address.
// - Interrupt flag register is read-only and reports the condition flags.
// - A sequencer forwards commands, drives bus-master and interrupt signals.
// - Code 6 transmit DMA, 7 receive DMA, 4 frame-ready interrupt, 0 disables all.
// - Any code write drops the interrupt request; code 0 keeps DMA from starting.
// - Transmit done at zero count with empty transmit register; address points onward.
`ifndef HBDMA_MAP_SVH
`define HBDMA_MAP_SVH
`define HBDMA_OFF_CMD       4'h0
`define HBDMA_OFF_STATUS    4'h1
`define HBDMA_OFF_TXDATA    4'h2
`define HBDMA_OFF_RXDATA    4'h3
`define HBDMA_OFF_FLAGS     4'h5
`define HBDMA_OFF_CODE      4'h8
`define HBDMA_OFF_ADDR_U    4'h9
`define HBDMA_OFF_ADDR_M    4'ha
`define HBDMA_OFF_ADDR_L    4'hb
`define HBDMA_OFF_CNT_U     4'hc
`define HBDMA_OFF_CNT_L     4'hd
`define HBDMA_CODE_OFF      3'h0
`define HBDMA_CODE_SRF      3'h1
`define HBDMA_CODE_SBA      3'h2
`define HBDMA_CODE_RDF      3'h3
`define HBDMA_CODE_RBA      3'h4
`define HBDMA_CODE_TDE      3'h5
`define HBDMA_CODE_TXDMA    3'h6
`define HBDMA_CODE_RXDMA    3'h7
`define HBDMA_FLAG_SRF      0
`define HBDMA_FLAG_SBA_N    1
`define HBDMA_FLAG_RDF      2
`define HBDMA_FLAG_RBA_N    3
`define HBDMA_FLAG_TDE_N    4
`define HBDMA_FLAG_DMA_DONE 5
`define HBDMA_CMD_SEND      8'h29
`define HBDMA_TX_DEPTH      16'h0600
`define HBDMA_RX_DEPTH      16'h3600
`define HBDMA_ADDR_W        16
`endif

//--- hw/hbdma_pkg.sv
package hbdma_pkg;
    typedef logic [7:0] hbdma_byte_t;
    typedef enum logic [2:0] {
        DMA_IDLE,
        DMA_TX_CHK,
        DMA_TX_REQ,
        DMA_RX_CHK,
        DMA_RX_REQ
    } hbdma_state_t;
endpackage : hbdma_pkg

//--- hw/hbdma_top.sv
`timescale 1ns/1ps
`include "hbdma_map.svh"
module hbdma_top
    import hbdma_pkg::*;
#(
    parameter int TX_DEPTH = `HBDMA_TX_DEPTH,
    parameter int RX_DEPTH = `HBDMA_RX_DEPTH,
    parameter int AW       = `HBDMA_ADDR_W
) (
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          resetn,
    // I/O slave port.
    input  wire logic [AW-1:0] io_base,
    input  wire logic [AW-1:0] io_addr,
    input  wire logic          io_rd,
    input  wire logic          io_wr,
    input  wire logic [7:0]    io_wdata,
    output logic [7:0]         io_rdata,
    output logic               io_ack,
    output logic               irq,
    // Bus-master memory port.
    output logic               mem_req,
    output logic               mem_we,
    output logic [23:0]        mem_addr,
    output logic [7:0]         mem_wdata,
    input  wire logic          mem_ack,
    input  wire logic [7:0]    mem_rdata,
    // Protocol module command and status.
    output logic               cmd_valid,
    output logic [7:0]         cmd_data,
    output logic [2:0]         pm_addr,
    input  wire logic          status_valid,
    input  wire logic [7:0]    status_data,
    input  wire logic          status_block_n,
    // Transmit stream toward the network.
    output logic               tx_out_valid,
    output logic [7:0]         tx_out_data,
    output logic               tx_out_last,
    input  wire logic          tx_out_ready,
    input  wire logic          tx_retry,
    input  wire logic          tx_sent,
    // Receive stream from the network.
    input  wire logic          rx_in_valid,
    input  wire logic [7:0]    rx_in_data,
    input  wire logic          rx_in_last,
    output logic               rx_in_ready
);
    localparam int TXW = $clog2(TX_DEPTH + 1);
    localparam int RXA = $clog2(RX_DEPTH);
    localparam int RXC = $clog2(RX_DEPTH + 1);
    localparam logic [TXW-1:0] TX_FULL = TXW'(TX_DEPTH);
    localparam logic [RXC-1:0] RX_FULL = RXC'(RX_DEPTH);
    localparam logic [RXA-1:0] RX_LAST = RXA'(RX_DEPTH - 1);

    logic [1:0]     rst_sync;
    logic           rst_n;
    logic [AW-1:0]  port_diff;
    logic [3:0]     port_off;
    logic           claim;
    logic           rd_hit;
    logic           wr_hit;

    hbdma_state_t   state_reg;
    logic [2:0]     code_reg;
    logic [23:0]    addr_reg;
    logic [11:0]    count_reg;
    logic           dma_done_reg;
    hbdma_byte_t    tx_byte_reg;
    logic           tx_hold_reg;
    hbdma_byte_t    rx_byte_reg;
    logic           rx_full_reg;
    hbdma_byte_t    status_byte_reg;
    logic           status_full_reg;
    logic [7:0]     flags;
    logic           irq_cond;

    hbdma_byte_t    tx_mem [TX_DEPTH];
    logic [TXW-1:0] tx_len_reg;
    logic [TXW-1:0] tx_rd_reg;
    logic           tx_send_reg;
    logic           tx_push;
    logic           tx_dma_load;

    logic [8:0]     rx_mem [RX_DEPTH];
    logic [RXA-1:0] rx_wr_reg;
    logic [RXA-1:0] rx_rd_reg;
    logic [RXC-1:0] rx_cnt_reg;
    logic [RXC-1:0] rx_cnt_next;
    logic [RXC-1:0] rx_frames_reg;
    logic           rx_push;
    logic           rx_pop;
    logic           rx_taken;
    logic           rx_pop_last;

    function automatic logic port_mapped(input logic [3:0] off);
        case (off)
            `HBDMA_OFF_CMD, `HBDMA_OFF_STATUS, `HBDMA_OFF_TXDATA, `HBDMA_OFF_RXDATA,
            `HBDMA_OFF_FLAGS, `HBDMA_OFF_CODE, `HBDMA_OFF_ADDR_U, `HBDMA_OFF_ADDR_M,
            `HBDMA_OFF_ADDR_L, `HBDMA_OFF_CNT_U, `HBDMA_OFF_CNT_L: port_mapped = 1'b1;
            default: port_mapped = 1'b0;
        endcase
    endfunction : port_mapped

    function automatic logic [RXA-1:0] rx_wrap(input logic [RXA-1:0] p);
        rx_wrap = (p == RX_LAST) ? '0 : p + 1'b1;
    endfunction : rx_wrap

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Address decode against the switch-selected base.
    assign port_diff = io_addr - io_base;
    assign port_off  = port_diff[3:0];
    assign claim     = (port_diff[AW-1:4] == '0) && port_mapped(port_off);
    assign rd_hit    = io_rd && claim;
    assign wr_hit    = io_wr && claim;

    // Read answer and acknowledge, one cycle after the strobe.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
            io_ack   <= 1'b0;
        end else begin
            io_ack <= rd_hit || wr_hit;
            if (rd_hit) begin
                case (port_off)
                    `HBDMA_OFF_STATUS: io_rdata <= status_byte_reg;
                    `HBDMA_OFF_RXDATA: io_rdata <= rx_byte_reg;
                    `HBDMA_OFF_FLAGS:  io_rdata <= flags;
                    default:           io_rdata <= 8'h00;
                endcase
            end else begin
                io_rdata <= 8'h00;
            end
        end
    end

    always_comb begin
        flags                       = 8'h00;
        flags[`HBDMA_FLAG_SRF]      = status_full_reg;
        flags[`HBDMA_FLAG_SBA_N]    = status_block_n;
        flags[`HBDMA_FLAG_RDF]      = rx_full_reg;
        flags[`HBDMA_FLAG_RBA_N]    = (rx_frames_reg == '0);
        flags[`HBDMA_FLAG_TDE_N]    = tx_hold_reg;
        flags[`HBDMA_FLAG_DMA_DONE] = dma_done_reg;
    end

    // Interrupt code register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_reg <= `HBDMA_CODE_OFF;
        end else if (wr_hit && port_off == `HBDMA_OFF_CODE) begin
            code_reg <= io_wdata[2:0];
        end
    end

    always_comb begin
        case (code_reg)
            `HBDMA_CODE_SRF:   irq_cond = status_full_reg;
            `HBDMA_CODE_SBA:   irq_cond = !status_block_n;
            `HBDMA_CODE_RDF:   irq_cond = rx_full_reg;
            `HBDMA_CODE_RBA:   irq_cond = (rx_frames_reg != '0);
            `HBDMA_CODE_TDE:   irq_cond = !tx_hold_reg;
            `HBDMA_CODE_TXDMA: irq_cond = dma_done_reg;
            `HBDMA_CODE_RXDMA: irq_cond = dma_done_reg;
            default:           irq_cond = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (wr_hit && port_off == `HBDMA_OFF_CODE) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_cond;
        end
    end

    // Address registers; host byte writes take precedence over the step.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 24'h00_0000;
        end else if (wr_hit && port_off == `HBDMA_OFF_ADDR_U) begin
            addr_reg[23:16] <= io_wdata;
        end else if (wr_hit && port_off == `HBDMA_OFF_ADDR_M) begin
            addr_reg[15:8] <= io_wdata;
        end else if (wr_hit && port_off == `HBDMA_OFF_ADDR_L) begin
            addr_reg[7:0] <= io_wdata;
        end else if (mem_req && mem_ack) begin
            addr_reg <= addr_reg + 24'h00_0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 12'h000;
        end else if (wr_hit && port_off == `HBDMA_OFF_CNT_U) begin
            count_reg[11:8] <= io_wdata[3:0];
        end else if (wr_hit && port_off == `HBDMA_OFF_CNT_L) begin
            count_reg[7:0] <= io_wdata;
        end else if (mem_req && mem_ack) begin
            count_reg <= count_reg - 12'h001;
        end
    end

    // DMA sequencer; a request is dropped after every byte.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DMA_IDLE;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 24'h00_0000;
            mem_wdata <= 8'h00;
        end else if (wr_hit && port_off == `HBDMA_OFF_CODE) begin
            mem_req <= 1'b0;
            case (io_wdata[2:0])
                `HBDMA_CODE_TXDMA: state_reg <= DMA_TX_CHK;
                `HBDMA_CODE_RXDMA: state_reg <= DMA_RX_CHK;
                default:           state_reg <= DMA_IDLE;
            endcase
        end else begin
            case (state_reg)
                DMA_TX_CHK: begin
                    if (count_reg == '0 && !tx_hold_reg) begin
                        state_reg <= DMA_IDLE;
                    end else if (count_reg != '0 && !tx_hold_reg) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b0;
                        mem_addr  <= addr_reg;
                        state_reg <= DMA_TX_REQ;
                    end
                end
                DMA_TX_REQ: begin
                    if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DMA_TX_CHK;
                    end
                end
                DMA_RX_CHK: begin
                    if (count_reg == '0) begin
                        state_reg <= DMA_IDLE;
                    end else if (rx_full_reg) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= addr_reg;
                        mem_wdata <= rx_byte_reg;
                        state_reg <= DMA_RX_REQ;
                    end
                end
                DMA_RX_REQ: begin
                    if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= DMA_RX_CHK;
                    end
                end
                default: begin
                    state_reg <= DMA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dma_done_reg <= 1'b0;
        end else if ((state_reg == DMA_TX_CHK && count_reg == '0 && !tx_hold_reg) ||
                     (state_reg == DMA_RX_CHK && count_reg == '0)) begin
            dma_done_reg <= 1'b1;
        end else if (wr_hit && port_off == `HBDMA_OFF_CODE) begin
            dma_done_reg <= 1'b0;
        end
    end

    // Transmit data register and packet buffer.
    assign tx_dma_load = (state_reg == DMA_TX_REQ) && mem_ack;
    assign tx_push     = tx_hold_reg && !tx_send_reg && (tx_len_reg != TX_FULL);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_reg <= 8'h00;
            tx_hold_reg <= 1'b0;
        end else if (tx_dma_load) begin
            tx_byte_reg <= mem_rdata;
            tx_hold_reg <= 1'b1;
        end else if (wr_hit && port_off == `HBDMA_OFF_TXDATA) begin
            tx_byte_reg <= io_wdata;
            tx_hold_reg <= 1'b1;
        end else if (tx_push) begin
            tx_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (tx_push) begin
            tx_mem[tx_len_reg[TXW-2:0]] <= tx_byte_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_len_reg   <= '0;
            tx_rd_reg    <= '0;
            tx_send_reg  <= 1'b0;
            tx_out_valid <= 1'b0;
            tx_out_data  <= 8'h00;
            tx_out_last  <= 1'b0;
        end else begin
            if (tx_push) begin
                tx_len_reg <= tx_len_reg + 1'b1;
            end
            if (cmd_valid && cmd_data == `HBDMA_CMD_SEND && !tx_send_reg) begin
                tx_send_reg <= 1'b1;
                tx_rd_reg   <= '0;
            end else if (tx_sent && tx_send_reg) begin
                tx_send_reg  <= 1'b0;
                tx_len_reg   <= '0;
                tx_out_valid <= 1'b0;
            end else if (tx_retry && tx_send_reg) begin
                tx_rd_reg    <= '0;
                tx_out_valid <= 1'b0;
            end else if (tx_send_reg && (!tx_out_valid || tx_out_ready)) begin
                if (tx_rd_reg != tx_len_reg) begin
                    tx_out_data  <= tx_mem[tx_rd_reg[TXW-2:0]];
                    tx_out_last  <= (tx_rd_reg + 1'b1 == tx_len_reg);
                    tx_out_valid <= 1'b1;
                    tx_rd_reg    <= tx_rd_reg + 1'b1;
                end else begin
                    tx_out_valid <= 1'b0;
                end
            end
        end
    end

    // Receive FIFO and receive data register.
    assign rx_push     = rx_in_valid && rx_in_ready;
    assign rx_taken    = (rd_hit && port_off == `HBDMA_OFF_RXDATA) ||
                         (state_reg == DMA_RX_REQ && mem_ack);
    assign rx_pop      = (rx_cnt_reg != '0) && (!rx_full_reg || rx_taken);
    assign rx_pop_last = rx_pop && rx_mem[rx_rd_reg][8];

    always_comb begin
        rx_cnt_next = rx_cnt_reg;
        if (rx_push && !rx_pop) begin
            rx_cnt_next = rx_cnt_reg + 1'b1;
        end else if (rx_pop && !rx_push) begin
            rx_cnt_next = rx_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rx_push) begin
            rx_mem[rx_wr_reg] <= {rx_in_last, rx_in_data};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wr_reg   <= '0;
            rx_rd_reg   <= '0;
            rx_cnt_reg  <= '0;
            rx_in_ready <= 1'b0;
        end else begin
            rx_cnt_reg  <= rx_cnt_next;
            rx_in_ready <= (rx_cnt_next < RX_FULL - 1'b1);
            if (rx_push) begin
                rx_wr_reg <= rx_wrap(rx_wr_reg);
            end
            if (rx_pop) begin
                rx_rd_reg <= rx_wrap(rx_rd_reg);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_frames_reg <= '0;
        end else if (rx_push && rx_in_last && !rx_pop_last) begin
            rx_frames_reg <= rx_frames_reg + 1'b1;
        end else if (rx_pop_last && !(rx_push && rx_in_last)) begin
            rx_frames_reg <= rx_frames_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte_reg <= 8'h00;
            rx_full_reg <= 1'b0;
        end else if (rx_pop) begin
            rx_byte_reg <= rx_mem[rx_rd_reg][7:0];
            rx_full_reg <= 1'b1;
        end else if (rx_taken) begin
            rx_full_reg <= 1'b0;
        end
    end

    // Command forwarding and status capture.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_data  <= 8'h00;
            pm_addr   <= 3'h0;
        end else begin
            cmd_valid <= wr_hit && port_off == `HBDMA_OFF_CMD;
            if (wr_hit && port_off == `HBDMA_OFF_CMD) begin
                cmd_data <= io_wdata;
            end
            if (rd_hit || wr_hit) begin
                pm_addr <= port_off[2:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_byte_reg <= 8'h00;
            status_full_reg <= 1'b0;
        end else if (status_valid) begin
            status_byte_reg <= status_data;
            status_full_reg <= 1'b1;
        end else if (rd_hit && port_off == `HBDMA_OFF_STATUS) begin
            status_full_reg <= 1'b0;
        end
    end
endmodule : hbdma_top

//--- verif/hbdma_mem_model.sv
`timescale 1ns/1ps
module hbdma_mem_model (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        resetn,
    // Master request from the device.
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    // Memory answer.
    output logic            mem_ack,
    output logic [7:0]      mem_rdata
);
    logic [7:0]  mem [256];
    logic [23:0] last_addr;
    logic        last_we;
    int          n_acks;
    int          dly;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    // Waits up to three cycles; data toggles while idle.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            dly <= 0;
            n_acks <= 0;
        end else if (!mem_req || mem_ack || dly != 0) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            dly <= (!mem_req || mem_ack) ? int'($urandom % 4) : dly - 1;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
            n_acks <= n_acks + 1;
            last_addr <= mem_addr;
            last_we <= mem_we;
        end
    end
endmodule : hbdma_mem_model

//--- verif/hbdma_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module hbdma_top_bench;
    logic mclk = 1'b0, resetn = 1'b0, io_rd = 1'b0, io_wr = 1'b0, status_valid = 1'b0, status_block_n = 1'b1;
    logic tx_out_ready = 1'b1, tx_retry = 1'b0, tx_sent = 1'b0, rx_in_valid = 1'b0, rx_in_last = 1'b0;
    logic [15:0] io_base = 16'h0000, io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00, status_data = 8'h00, rx_in_data = 8'h00;
    logic [7:0]  io_rdata, mem_wdata, mem_rdata, cmd_data, tx_out_data, r, c, s;
    logic        io_ack, irq, mem_req, mem_we, mem_ack, cmd_valid, tx_out_valid, tx_out_last, rx_in_ready;
    logic [23:0] mem_addr, a;
    logic [11:0] n;
    logic [2:0]  pm_addr;
    logic [7:0]  e[$];
    int miscompares = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;
    hbdma_top #(.TX_DEPTH(16), .RX_DEPTH(16), .AW(16)) u_hbdma_top (.mclk, .resetn, .io_base, .io_addr, .io_rd,
        .io_wr, .io_wdata, .io_rdata, .io_ack, .irq, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata, .cmd_valid, .cmd_data, .pm_addr, .status_valid, .status_data, .status_block_n, .tx_out_valid,
        .tx_out_data, .tx_out_last, .tx_out_ready, .tx_retry, .tx_sent, .rx_in_valid, .rx_in_data, .rx_in_last,
        .rx_in_ready);
    hbdma_mem_model u_hbdma_mem_model (.mclk, .resetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata);
    task automatic io(input logic rd, input logic [3:0] off, input logic [7:0] wd, output logic [7:0] q,
                      output logic ok);
        @(posedge mclk);
        io_addr <= io_base + 16'(off);
        io_rd <= rd;
        io_wr <= ~rd;
        io_wdata <= wd;
        @(posedge mclk);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        ok = 1'b0;
        q = 8'h00;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(negedge mclk);
            ok = (io_ack === 1'b1);
            q = io_rdata;
        end
    endtask : io
    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        io(1'b0, off, d, q, ok);
        `CHK("write ack", 1'b1, ok)
    endtask : wr
    task automatic rd(input logic [3:0] off);
        logic ok;
        io(1'b1, off, 8'h00, r, ok);
        `CHK("read ack", 1'b1, ok)
    endtask : rd
    task automatic pulse(input logic [2:0] sel);
        @(posedge mclk);
        tx_retry <= sel[0];
        tx_sent <= sel[1];
        status_valid <= sel[2];
        status_data <= s;
        @(posedge mclk);
        {tx_retry, tx_sent, status_valid} <= 3'b000;
    endtask : pulse
    task automatic wirq;
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge mclk);
        `CHK("irq", 1'b1, irq)
    endtask : wirq
    task automatic take;
        int k = 0;
        for (int i = 0; i < 200 && k < e.size(); i++) begin
            @(negedge mclk);
            if (tx_out_valid === 1'b1) begin
                `CHK("tx byte", e[k], tx_out_data)
                `CHK("tx last", k == e.size() - 1, tx_out_last)
                k++;
            end
        end
        `CHK("tx beats", e.size(), k)
    endtask : take
    task automatic rxb(input logic [7:0] d, input logic l);
        @(posedge mclk);
        {rx_in_valid, rx_in_data, rx_in_last} <= {1'b1, d, l};
        do @(posedge mclk); while (rx_in_ready !== 1'b1);
        {rx_in_valid, rx_in_data} <= {1'b0, ~d};
    endtask : rxb
    task automatic dma(input logic [7:0] code);
        int n0 = u_hbdma_mem_model.n_acks;
        wr(4'h8, 8'h00);
        for (int i = 0; i < 3; i++) wr(4'(9 + i), a[23 - 8 * i -: 8]);
        wr(4'hc, {4'($urandom), n[11:8]});
        wr(4'hd, n[7:0]);
        repeat (4) @(negedge mclk);
        `CHK("idle req", 1'b0, mem_req)
        wr(4'h8, code);
        wirq();
        rd(4'h5);
        `CHK("done flag", 1'b1, r[5])
        `CHK("bytes", int'(n), u_hbdma_mem_model.n_acks - n0)
        if (n != 0) `CHK("last addr", a + 24'(n) - 24'd1, u_hbdma_mem_model.last_addr)
        wr(4'h8, 8'h00);
        `CHK("irq off", 1'b0, irq)
    endtask : dma
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        void'($urandom(92549));
        io_base <= 16'($urandom) & 16'hfff0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(4'h5);
        `CHK("flags", 8'h0a, r)
        rd(4'h8);
        `CHK("wo read", 8'h00, r)
        wr(4'h5, 8'hff);
        rd(4'h5);
        `CHK("ro write", 8'h0a, r)
        for (int i = 0; i < 16; i++) if (i == 4 || i == 6 || i == 7 || i > 13) begin
            io(i[0], 4'(i), 8'h00, r, c[0]);
            `CHK("no ack", 1'b0, c[0])
        end
        $display("test map done");
        repeat (3) begin
            c = 8'($urandom);
            s = 8'($urandom);
            wr(4'h0, c);
            `CHK("cmd", c, cmd_data)
            pulse(3'b100);
            rd(4'h5);
            `CHK("status full", 1'b1, r[0])
            rd(4'h1);
            `CHK("status", s, r)
        end
        $display("test command done");
        a = 24'($urandom);
        n = 12'h000;
        dma(8'hf6);
        n = 12'(2 + $urandom % 4);
        dma(8'h06);
        for (int i = 0; i < n; i++) e.push_back(8'(a + 24'(i)) ^ 8'ha5);
        wr(4'h0, 8'h29);
        take();
        pulse(3'b001);
        take();
        pulse(3'b010);
        $display("test tx dma done");
        wr(4'h8, 8'h05);
        c = 8'($urandom);
        wr(4'h2, c);
        wirq();
        rd(4'h5);
        `CHK("tx empty", 1'b0, r[4])
        e = {c};
        wr(4'h0, 8'h29);
        take();
        pulse(3'b010);
        $display("test tx direct done");
        s = 8'($urandom);
        rxb(s, 1'b0);
        rxb(~s, 1'b1);
        wr(4'h8, 8'h03);
        wirq();
        rd(4'h5);
        `CHK("rx full", 1'b1, r[2])
        rd(4'h3);
        `CHK("rx byte", s, r)
        a = 24'($urandom);
        n = 12'h001;
        dma(8'h07);
        `CHK("rx mem", ~s, u_hbdma_mem_model.mem[a[7:0]])
        $display("test rx done");
        test_done();
    end
endmodule : hbdma_top_bench

//--- verif/hbdma_top_chk.sv
`timescale 1ns/1ps
module hbdma_top_chk #(parameter int AW = 16) (
    // Watched top ports.
    input logic          mclk,
    input logic          resetn,
    input logic [AW-1:0] io_base,
    input logic [AW-1:0] io_addr,
    input logic          io_rd,
    input logic          io_wr,
    input logic [7:0]    io_wdata,
    input logic [7:0]    io_rdata,
    input logic          io_ack,
    input logic          irq,
    input logic          mem_req,
    input logic          mem_we,
    input logic [23:0]   mem_addr,
    input logic          mem_ack,
    input logic          cmd_valid,
    input logic [7:0]    cmd_data,
    input logic [2:0]    pm_addr
);
    logic [AW-1:0] off;
    logic [2:0]    off3;
    logic          claim;
    logic          cmd_wr;
    logic          code_wr;
    assign off = io_addr - io_base;
    assign off3 = off[2:0];
    assign claim = (io_rd | io_wr) && off < AW'(14) && !(off inside {AW'(4), AW'(6), AW'(7)});
    assign cmd_wr = io_wr && off == AW'(0);
    assign code_wr = io_wr && off == AW'(8);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_claim_gets_ack: assert property (claim |=> io_ack)
        else $error("claim not acked");
    a_ack_has_cause: assert property (io_ack |-> $past(claim))
        else $error("ack without claim");
    a_rdata_idle_zero: assert property (!io_ack |-> io_rdata == 8'h00)
        else $error("read data outside acknowledge");
    a_cmd_forwarded: assert property (cmd_wr |=> cmd_valid && cmd_data == $past(io_wdata))
        else $error("command not forwarded");
    a_cmd_has_cause: assert property (cmd_valid |-> $past(cmd_wr))
        else $error("command pulse without write");
    a_pm_addr_follows: assert property (claim |=> pm_addr == $past(off3))
        else $error("internal address wrong");
    a_code_drops_irq: assert property (code_wr |=> !irq)
        else $error("irq kept after code write");
    a_req_holds: assert property (mem_req && !mem_ack && !code_wr && !$past(code_wr) |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("request not held");
    a_req_one_byte: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("request kept after ack");
    c_mem_read: cover property (mem_req && mem_ack && !mem_we);
    c_mem_write: cover property (mem_req && mem_ack && mem_we);
    c_cmd: cover property (cmd_valid);
endmodule : hbdma_top_chk

bind hbdma_top hbdma_top_chk #(.AW(AW)) u_hbdma_top_chk (.mclk, .resetn, .io_base, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .io_ack, .irq, .mem_req, .mem_we, .mem_addr, .mem_ack, .cmd_valid, .cmd_data, .pm_addr);
